// ==== design/stepper_phase_shifter.sv ====
// two-channel timer-triggered stepping motor phase shifter with wishbone registers
// Summary of operation
// - each rising trigger edge shifts the pattern one step and drives the 4-bit output latch to pins
// - direction 0 shifts phase 0 toward phase 3; direction 1 shifts the other way
// - full-step mode rotates only the latch; shadow nibble is left untouched
// - half-step mode shifts latch and shadow nibble together as one 8-bit ring
// - pulse-mode timers trigger only on cycle compare match, not duty match
// - pwm-mode source timer never produces a shift trigger
// - wide timer triggers only when its counter equals its second compare
// - mode bit 0 selects full step, 1 selects half step
// - trigger-enable bit 0 blocks triggers, 1 passes them
// - source select 0 takes the 8-bit timer pair, 1 takes the wide timer
// - the two channels run independently with own control, pattern and trigger
`timescale 1ns/1ps

module stepper_phase_shifter #(
  parameter int CHANNELS = 2
) (
  input  wire logic                                   clk_sys_i,
  input  wire logic                                   nrst_i,
  // wishbone classic slave
  input  wire logic                                   wb_cyc_i,
  input  wire logic                                   wb_stb_i,
  input  wire logic                                   wb_we_i,
  input  wire logic [stepper_phase_shifter_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                             wb_sel_i,
  input  wire logic [31:0]                            wb_dat_i,
  output logic      [31:0]                            wb_dat_o,
  output logic                                        wb_ack_o,
  // 8-bit timer pair per channel
  input  wire logic [CHANNELS-1:0][1:0]               timer_mode_i,
  input  wire logic [CHANNELS-1:0]                    timer_a_match_i,
  input  wire logic [CHANNELS-1:0]                    timer_b_match_i,
  input  wire logic [CHANNELS-1:0]                    flipflop_invert_enable_i,
  // wide timer, shared by both channels
  input  wire logic                                   wide_timer_match_b_i,
  input  wire logic                                   match_b_event_enable_a_i,
  input  wire logic                                   match_b_event_enable_b_i,
  // phase outputs, bit k is phase k
  output logic      [3:0]                             step_channel_0_o,
  output logic      [3:0]                             step_channel_1_o
);

  // one ring step; the half-step ring runs 4->1->5->2->6->3->7->0->4 when normal
  function automatic logic [7:0] shift_pattern(input logic [7:0] p, input logic half, input logic rev);
    logic [7:0] r;
    r = p;
    if (half) begin
      if (!rev) begin
        r = {p[3], p[2], p[1], p[0], p[6], p[5], p[4], p[7]};
      end else begin
        r = {p[0], p[3], p[2], p[1], p[7], p[6], p[5], p[4]};
      end
    end else begin
      if (!rev) begin
        r[7:4] = {p[6:4], p[7]};
      end else begin
        r[7:4] = {p[4], p[7:5]};
      end
    end
    return r;
  endfunction : shift_pattern

  // true when a register index matches the word address on the bus
  function automatic logic hit(input logic [stepper_phase_shifter_pkg::ADR_W-1:0] adr, input logic [7:0] idx);
    return adr[stepper_phase_shifter_pkg::ADR_W-1:stepper_phase_shifter_pkg::ADR_LSB] == idx;
  endfunction : hit

  logic [7:0]                ctrl_q;
  logic [7:0]                ctrl_d;
  logic [7:0]                trig_source_q;
  logic [7:0]                trig_source_d;
  logic [CHANNELS-1:0][7:0]  pattern_q;
  logic [CHANNELS-1:0][7:0]  pattern_d;
  logic [CHANNELS-1:0]       trig_prev_q;
  logic [CHANNELS-1:0]       trig_prev_d;
  logic [CHANNELS-1:0]       trig_level;
  logic                      ack_q;
  logic                      ack_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic                      bus_req;
  logic                      bus_wr;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

  // trigger path per channel
  always_comb begin
    logic       timer8_trig;
    logic       wide_trig;
    logic       src_wide;
    logic [3:0] nib;
    timer8_trig = 1'b0;
    wide_trig   = 1'b0;
    src_wide    = 1'b0;
    nib         = 4'h0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      case (stepper_phase_shifter_pkg::timer_mode_type'(timer_mode_i[ch]))
        stepper_phase_shifter_pkg::TIMER_8BIT:  timer8_trig = timer_a_match_i[ch];
        stepper_phase_shifter_pkg::TIMER_16BIT: timer8_trig = timer_a_match_i[ch] && timer_b_match_i[ch];
        stepper_phase_shifter_pkg::TIMER_PPG:   timer8_trig = timer_b_match_i[ch];
        stepper_phase_shifter_pkg::TIMER_PWM:   timer8_trig = 1'b0;
        default:                                timer8_trig = 1'b0;
      endcase
      timer8_trig = timer8_trig && flipflop_invert_enable_i[ch];
      wide_trig   = wide_timer_match_b_i && (match_b_event_enable_a_i || match_b_event_enable_b_i);
      src_wide    = (ch == 0) ? trig_source_q[stepper_phase_shifter_pkg::SRC_SEL_0]
                              : trig_source_q[stepper_phase_shifter_pkg::SRC_SEL_1];
      nib         = ctrl_q[ch*stepper_phase_shifter_pkg::CTRL_NIBBLE_W +: stepper_phase_shifter_pkg::CTRL_NIBBLE_W];
      trig_level[ch] = nib[stepper_phase_shifter_pkg::CTRL_TRIG_ENABLE]
                       && (src_wide ? wide_trig : timer8_trig);
    end
  end

  // register file and shifters
  always_comb begin
    logic [3:0] nib;
    logic [7:0] idx;
    logic [7:0] wbyte;
    nib           = 4'h0;
    idx           = 8'h00;
    wbyte         = wb_dat_i[7:0];
    ctrl_d        = ctrl_q;
    trig_source_d = trig_source_q;
    pattern_d     = pattern_q;
    trig_prev_d   = trig_level;
    ack_d         = bus_req;
    rdata_d       = 32'h0000_0000;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      nib = ctrl_q[ch*stepper_phase_shifter_pkg::CTRL_NIBBLE_W +: stepper_phase_shifter_pkg::CTRL_NIBBLE_W];
      idx = (ch == 0) ? stepper_phase_shifter_pkg::IDX_PATTERN_0 : stepper_phase_shifter_pkg::IDX_PATTERN_1;
      if (trig_level[ch] && !trig_prev_q[ch]) begin
        pattern_d[ch] = shift_pattern(pattern_q[ch],
                                      nib[stepper_phase_shifter_pkg::CTRL_HALF_STEP],
                                      nib[stepper_phase_shifter_pkg::CTRL_REVERSE_DIR]);
      end
      // a write in the shift cycle wins, so software sees exactly what it loaded
      if (bus_wr && hit(wb_adr_i, idx)) begin
        if (nib[stepper_phase_shifter_pkg::CTRL_NIBBLE_WRITE]) begin
          pattern_d[ch][3:0] = wbyte[3:0];
        end else begin
          pattern_d[ch] = wbyte;
        end
      end
      if (bus_req && !wb_we_i && hit(wb_adr_i, idx)) begin
        rdata_d[7:0] = pattern_q[ch];
      end
    end
    if (bus_wr && hit(wb_adr_i, stepper_phase_shifter_pkg::IDX_CTRL)) begin
      ctrl_d = wbyte;
    end else if (bus_wr && hit(wb_adr_i, stepper_phase_shifter_pkg::IDX_TRIG_SOURCE)) begin
      trig_source_d = wbyte & stepper_phase_shifter_pkg::TRIG_SOURCE_MASK;
    end
    if (bus_req && !wb_we_i) begin
      if (hit(wb_adr_i, stepper_phase_shifter_pkg::IDX_CTRL)) begin
        rdata_d[7:0] = ctrl_q;
      end else if (hit(wb_adr_i, stepper_phase_shifter_pkg::IDX_TRIG_SOURCE)) begin
        rdata_d[7:0] = trig_source_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ctrl_q        <= stepper_phase_shifter_pkg::CTRL_RST;
      trig_source_q <= stepper_phase_shifter_pkg::TRIG_SOURCE_RST;
      pattern_q     <= '{default: stepper_phase_shifter_pkg::PATTERN_RST};
      trig_prev_q   <= '0;
      ack_q         <= 1'b0;
      rdata_q       <= 32'h0000_0000;
    end else begin
      ctrl_q        <= ctrl_d;
      trig_source_q <= trig_source_d;
      pattern_q     <= pattern_d;
      trig_prev_q   <= trig_prev_d;
      ack_q         <= ack_d;
      rdata_q       <= rdata_d;
    end
  end

  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdata_q;
  assign step_channel_0_o = pattern_q[0][stepper_phase_shifter_pkg::LATCH_LSB +: 4];
  assign step_channel_1_o = pattern_q[CHANNELS-1][stepper_phase_shifter_pkg::LATCH_LSB +: 4];

endmodule : stepper_phase_shifter

// ==== design/stepper_phase_shifter_pkg.sv ====
// constants for the timer-synchronised stepping motor phase shifter
package stepper_phase_shifter_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRIG_SOURCE = 8'h3A;
  localparam logic [7:0] IDX_PATTERN_0   = 8'h4C;
  localparam logic [7:0] IDX_PATTERN_1   = 8'h4D;
  localparam logic [7:0] IDX_CTRL        = 8'h4E;
  localparam int         ADR_LSB         = 2;
  localparam int         ADR_W           = 10;

  // reset values
  localparam logic [7:0] CTRL_RST        = 8'h00;
  localparam logic [7:0] PATTERN_RST     = 8'h00;
  localparam logic [7:0] TRIG_SOURCE_RST = 8'h00;

  // per-channel control nibble, channel n at bit 4*n
  localparam int CTRL_NIBBLE_W     = 4;
  localparam int CTRL_TRIG_ENABLE  = 0;
  localparam int CTRL_HALF_STEP    = 1;
  localparam int CTRL_REVERSE_DIR  = 2;
  localparam int CTRL_NIBBLE_WRITE = 3;

  // trigger source register fields
  localparam int SRC_DOUBLE_BUF = 0;
  localparam int SRC_SEL_0      = 2;
  localparam int SRC_SEL_1      = 3;
  localparam logic [7:0] TRIG_SOURCE_MASK = 8'h0D;

  // pattern register: output latch high nibble, shadow low nibble
  localparam int LATCH_LSB  = 4;
  localparam int SHADOW_LSB = 0;

  typedef enum logic [1:0] {
    TIMER_8BIT  = 2'b00,
    TIMER_16BIT = 2'b01,
    TIMER_PPG   = 2'b10,
    TIMER_PWM   = 2'b11
  } timer_mode_type;
endpackage : stepper_phase_shifter_pkg

// ==== tb/stepper_phase_shifter_assertions.sv ====
// concurrent checks on the phase shifter ports
`timescale 1ns/1ps
module stepper_phase_shifter_assertions #(
  parameter int CHANNELS = 2
) (
  input wire logic                clk_sys_i,
  input wire logic                nrst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [CHANNELS-1:0] timer_a_match_i,
  input wire logic [CHANNELS-1:0] timer_b_match_i,
  input wire logic                wide_timer_match_b_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [3:0]          step_channel_0_o,
  input wire logic [3:0]          step_channel_1_o
);
  logic [2*CHANNELS:0] in_d, in_q, rise;
  logic                wr;
  // raw match rises; the gating is not visible here, so this only bounds when a shift may happen
  always_comb begin
    in_d = {wide_timer_match_b_i, timer_b_match_i, timer_a_match_i};
    rise = in_d & ~in_q;
    wr   = wb_we_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  end
  always_ff @(posedge clk_sys_i) begin
    in_q <= in_d;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after a request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack while bus idle");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a taken request");
  property p_dat_high; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_dat_high: assert property (p_dat_high) else $error("read data above low byte not zero");
  property p_reset; disable iff (1'b0) !nrst_i |=> !wb_ack_o && step_channel_0_o == 4'h0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_hold_0;
    $changed(step_channel_0_o) && $past(nrst_i) |-> $past(wr || rise[0] || rise[CHANNELS] || rise[2*CHANNELS]);
  endproperty
  a_hold_0: assert property (p_hold_0) else $error("channel 0 moved without trigger or write");
  property p_hold_1;
    $changed(step_channel_1_o) && $past(nrst_i) |-> $past(wr || rise[1] || rise[CHANNELS+1] || rise[2*CHANNELS]);
  endproperty
  a_hold_1: assert property (p_hold_1) else $error("channel 1 moved without trigger or write");
  c_move_0: cover property ($changed(step_channel_0_o) && !$past(wr));
  c_move_1: cover property ($changed(step_channel_1_o) && !$past(wr));
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : stepper_phase_shifter_assertions

bind stepper_phase_shifter stepper_phase_shifter_assertions #(.CHANNELS(CHANNELS)) chk (.*);

// ==== tb/stepper_coil_stage.sv ====
// registered motor driver stage on both phase nibbles
`timescale 1ns/1ps
module stepper_coil_stage (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] phase_0_i,
  input  wire logic [3:0] phase_1_i,
  output logic      [7:0] coil_o
);
  always_ff @(posedge clk_sys_i) begin
    coil_o <= {phase_1_i, phase_0_i};
  end
endmodule : stepper_coil_stage

// ==== tb/stepper_phase_shifter_tb.sv ====
// random self-checking bench for the stepping motor phase shifter
`timescale 1ns/1ps
module stepper_phase_shifter_tb;
  logic            clk_sys_i, nrst_i = 1'b0, req = 1'b0, we = 1'b0, wide = 1'b0, ea = 1'b0, eb = 1'b0, ack;
  logic [9:0]      adr = 10'h000;
  logic [31:0]     wdat = 32'h0, rdat, rnd = 32'h00011966;
  logic [1:0][1:0] md = 4'h0;
  logic [1:0]      ma = 2'h0, mb = 2'h0, inv = 2'h0;
  logic [3:0]      ph [2];
  logic [7:0]      pat [2], ctrl, src;
  int              bad_count = 0, checks = 0;
  localparam int   RING [8] = '{4, 1, 5, 2, 6, 3, 7, 0};
  function automatic logic [7:0] nxt(input logic [7:0] p, input logic h, input logic r);
    logic [7:0] n;
    n = {r ? {p[4], p[7:5]} : {p[6:4], p[7]}, p[3:0]};
    if (h) for (int i = 0; i < 8; i++) n[RING[r ? i : (i + 1) % 8]] = p[RING[r ? (i + 1) % 8 : i]];
    return n;
  endfunction : nxt
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // for a read, d is the expected byte
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    if (!w) chk(rdat[7:0], d);
    req <= 1'b0;
  endtask : bus
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  stepper_phase_shifter #(.CHANNELS(2)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_mode_i(md), .timer_a_match_i(ma), .timer_b_match_i(mb),
    .flipflop_invert_enable_i(inv), .wide_timer_match_b_i(wide), .match_b_event_enable_a_i(ea),
    .match_b_event_enable_b_i(eb), .step_channel_0_o(ph[0]), .step_channel_1_o(ph[1]));
  stepper_coil_stage coil (.clk_sys_i(clk_sys_i), .phase_0_i(ph[0]), .phase_1_i(ph[1]), .coil_o());
  initial begin
    pat = '{8'h00, 8'h00};
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    bus(1'b0, 10'h138, 8'h00);
    bus(1'b0, 10'h000, 8'h00);
    for (int n = 0; n < 300; n++) begin
      rnd = lfsr(rnd);
      // software seeds and controls are random after a first pass fixed at ctrl 03 and seed C8; no seed shape is assumed by the model
      ctrl = n == 0 ? 8'h03 : rnd[7:0];
      src = rnd[15:8] & 8'h0D;
      bus(1'b1, 10'h138, ctrl);
      bus(1'b1, 10'h0E8, src);
      for (int c = 0; c < 2; c++) begin
        rnd = lfsr(rnd);
        bus(1'b1, 10'h130 + 10'(4 * c), n == 0 ? 8'hC8 : rnd[7:0]);
        pat[c] = n == 0 ? 8'hC8 : ctrl[4 * c + 3] ? {pat[c][7:4], rnd[3:0]} : rnd[7:0];
      end
      rnd = lfsr(rnd);
      @(posedge clk_sys_i);
      ma <= rnd[1:0];
      mb <= rnd[3:2];
      wide <= rnd[4];
      inv <= rnd[6:5];
      ea <= rnd[7];
      eb <= rnd[8];
      md <= {rnd[10:9], rnd[12:11]};
      @(posedge clk_sys_i);
      for (int c = 0; c < 2; c++)
        if (ctrl[4 * c] && (src[2 + c] ? wide && (ea || eb) : inv[c] && (md[c] == 2'h0 ? ma[c] :
            md[c] == 2'h1 ? ma[c] && mb[c] : md[c] == 2'h2 && mb[c])))
          pat[c] = nxt(pat[c], ctrl[4 * c + 1], ctrl[4 * c + 2]);
      ma <= 2'h0;
      mb <= 2'h0;
      wide <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk({4'h0, ph[0]}, {4'h0, pat[0][7:4]});
      chk({4'h0, ph[1]}, {4'h0, pat[1][7:4]});
      bus(1'b0, 10'h130, pat[0]);
      bus(1'b0, 10'h134, pat[1]);
      bus(1'b0, 10'h0E8, src);
      bus(1'b0, 10'h138, ctrl);
    end
    end_of_test();
  end
endmodule : stepper_phase_shifter_tb
